// ### hdl/dnco_serial_loader.sv
// numeric oscillator with cosine table and write-only serial loader
// assumes serialClk comes from the host and may stop between frames;
// sys_rst is synchronous to ref_clk; select pins are asynchronous
//
// Operation
// - phase accumulator is 32 bits, full range
// - increment from frequency word 0 or 1
// - switching words never clears the accumulated phase
// - offset added to accumulator top bits
// - two choice bits pick one of four offsets
// - top 12 phase bits address cosine table
// - table output is a 10-bit converter code
// - each write is 16 framed bits
// - bits captured on falling serial clock edges
// - serial clock may idle either level
// - word holds command, address, data byte
// - deferred command fills holding half only
// - direct command writes 16 bits to a frequency half, 12 bits to an offset
// - command 0100 sets phase choice bits
// - command 0101 sets frequency choice bit
// - command 0110 sets both choices at once
// - frequency words are 32 bits each
// - destination loads one core clock after the data register fills
// - transfers only after the sixteenth edge
// - select pins sampled on rising core edge
`timescale 1ns/1ps

module dnco_serial_loader
  import dnco_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             serialClk,
  input  wire logic             frameSyncN,
  input  wire logic             serialDataIn,
  input  wire logic             freqWordChoicePin,
  input  wire logic             phaseChoiceLowPin,
  input  wire logic             phaseChoiceHighPin,
  output logic      [DAC_W-1:0] dacCode
);

  // cosine rom, built once at elaboration with quarter-wave symmetry;
  // a rational approximation avoids real math so the table synthesises
  function automatic logic [DAC_W-1:0] dnco_cos(input int idx);
    int quad;
    int q;
    int t;
    int mag;
    int res;
    quad = idx / QUARTER;
    q    = idx % QUARTER;
    t    = ((quad == 1) || (quad == 3)) ? (QUARTER - q) : q;
    mag  = (COS_AMP * 4 * (QUARTER * QUARTER - t * t)) /
           (4 * QUARTER * QUARTER + t * t);
    res  = ((quad == 1) || (quad == 2)) ? (DAC_MID - mag) : (DAC_MID + mag);
    return res[DAC_W-1:0];
  endfunction

  logic [DAC_W-1:0] cosRom [LUT_DEPTH];

  genvar g;
  generate
    for (g = 0; g < LUT_DEPTH; g++) begin : gen_rom
      assign cosRom[g] = dnco_cos(g);
    end
  endgenerate

  // ---------------- link domain (falling serialClk) ----------------
  logic [CNT_W-1:0]  bitCount_reg;
  logic [CNT_W-1:0]  bitCount_next;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [WORD_W-1:0] linkWord_reg;
  logic [WORD_W-1:0] linkWord_next;
  logic              linkDone_reg;
  logic              linkDone_next;

  // shift in while framed; the word is only published at the last bit
  always_comb begin
    bitCount_next = bitCount_reg;
    shift_next    = shift_reg;
    linkWord_next = linkWord_reg;
    linkDone_next = linkDone_reg;
    if (!frameSyncN && (bitCount_reg < FRAME_BITS)) begin
      shift_next    = {shift_reg[WORD_W-2:0], serialDataIn};
      bitCount_next = bitCount_reg + 5'h01;
      if (bitCount_reg == '0) begin
        linkDone_next = 1'b0;       // done level held until next frame starts
      end
      if (bitCount_reg == LAST_BIT) begin
        linkWord_next = {shift_reg[WORD_W-2:0], serialDataIn};
        linkDone_next = 1'b1;
      end
    end
  end

  // frame sync high clears the count without a clock edge, so an idle
  // or stopped serial clock between frames does no harm
  always_ff @(negedge serialClk or posedge frameSyncN) begin
    if (frameSyncN) begin
      bitCount_reg <= '0;
    end else begin
      bitCount_reg <= bitCount_next;
    end
  end

  // data path on the link clock, no reset needed
  always_ff @(negedge serialClk) begin
    shift_reg    <= shift_next;
    linkWord_reg <= linkWord_next;
    linkDone_reg <= linkDone_next;
  end

  // ---------------- core domain (rising ref_clk) ----------------
  logic [2:0] pinSync1_reg;
  logic [2:0] pinSync2_reg;
  logic       doneSync1_reg;
  logic       doneSync2_reg;
  logic       doneSeen_reg;
  logic       newWord;

  // two-flop synchronisers for select pins and the link done level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinSync1_reg  <= 3'h0;
      pinSync2_reg  <= 3'h0;
      doneSync1_reg <= 1'b0;
      doneSync2_reg <= 1'b0;
      doneSeen_reg  <= 1'b0;
    end else begin
      pinSync1_reg  <= {phaseChoiceHighPin, phaseChoiceLowPin, freqWordChoicePin};
      pinSync2_reg  <= pinSync1_reg;
      doneSync1_reg <= linkDone_reg;
      doneSync2_reg <= doneSync1_reg;
      doneSeen_reg  <= doneSync2_reg;
    end
  end

  // linkWord is stable for a whole frame after done rises, so it is
  // safe to read once the synchronised done level has been seen
  assign newWord = doneSync2_reg & ~doneSeen_reg;

  logic [3:0]        wordCmd;
  logic [3:0]        wordAddr;
  logic [BYTE_W-1:0] wordData;

  // field split of the received word
  assign wordCmd  = linkWord_reg[CMD_MSB:CMD_LSB];
  assign wordAddr = linkWord_reg[ADDR_MSB:ADDR_LSB];
  assign wordData = linkWord_reg[DATA_MSB:0];

  logic [WORD_W-1:0] hold_reg;
  logic [WORD_W-1:0] hold_next;
  logic [WORD_W-1:0] data_reg;
  logic [WORD_W-1:0] data_next;
  logic [3:0]        destAddr_reg;
  logic [3:0]        destAddr_next;
  logic              destPhase_reg;
  logic              destPhase_next;
  dnco_load_t        loadState_reg;
  dnco_load_t        loadState_next;
  logic              choiceSource_reg;
  logic              choiceSource_next;
  logic              freqChoice_reg;
  logic              freqChoice_next;
  logic [1:0]        phaseChoice_reg;
  logic [1:0]        phaseChoice_next;
  logic [ACC_W-1:0]  freqWord_reg [2];
  logic [ACC_W-1:0]  freqWord_next [2];
  logic [OFS_W-1:0]  phaseOffset_reg [4];
  logic [OFS_W-1:0]  phaseOffset_next [4];
  logic [WORD_W-1:0] holdMerged;

  // holding register with the addressed byte replaced
  always_comb begin
    holdMerged = hold_reg;
    if (wordAddr[ADDR_BYTE_BIT]) begin
      holdMerged[WORD_W-1:BYTE_W] = wordData;
    end else begin
      holdMerged[BYTE_W-1:0] = wordData;
    end
  end

  // command decode and destination load sequencer
  always_comb begin
    hold_next         = hold_reg;
    data_next         = data_reg;
    destAddr_next     = destAddr_reg;
    destPhase_next    = destPhase_reg;
    loadState_next    = loadState_reg;
    choiceSource_next = choiceSource_reg;
    freqChoice_next   = freqChoice_reg;
    phaseChoice_next  = phaseChoice_reg;
    freqWord_next     = freqWord_reg;
    phaseOffset_next  = phaseOffset_reg;
    case (loadState_reg)
      LD_IDLE: begin
        if (newWord) begin
          case (wordCmd)
            CMD_PHASE_DEFER, CMD_FREQ_DEFER: begin
              hold_next = holdMerged;
            end
            CMD_PHASE_DIRECT, CMD_FREQ_DIRECT: begin
              hold_next      = holdMerged;
              data_next      = holdMerged;
              destAddr_next  = wordAddr;
              destPhase_next = (wordCmd == CMD_PHASE_DIRECT);
              loadState_next = LD_WRITE;
            end
            CMD_PHASE_CHOICE: begin
              phaseChoice_next = {linkWord_reg[PHASE_HIGH_BIT],
                                  linkWord_reg[PHASE_LOW_BIT]};
            end
            CMD_FREQ_CHOICE: begin
              freqChoice_next = linkWord_reg[FREQ_CHOICE_BIT];
            end
            CMD_BOTH_CHOICE: begin
              phaseChoice_next = {linkWord_reg[PHASE_HIGH_BIT],
                                  linkWord_reg[PHASE_LOW_BIT]};
              freqChoice_next  = linkWord_reg[FREQ_CHOICE_BIT];
            end
            default: begin
              // reserved 0111 and the power commands are ignored
              if (linkWord_reg[CTL_MSB:CTL_LSB] == CTL_SOURCE) begin
                choiceSource_next = linkWord_reg[SOURCE_BIT];
              end
            end
          endcase
        end
      end
      LD_WRITE: begin
        // one core clock after the data register fills
        if (destPhase_reg) begin
          phaseOffset_next[destAddr_reg[OFS_IDX_MSB:OFS_IDX_LSB]] =
            data_reg[OFS_W-1:0];
        end else if (destAddr_reg[ADDR_HALF_BIT]) begin
          freqWord_next[destAddr_reg[ADDR_WORD_BIT]][ACC_W-1:WORD_W] =
            data_reg;
        end else begin
          freqWord_next[destAddr_reg[ADDR_WORD_BIT]][WORD_W-1:0] = data_reg;
        end
        loadState_next = LD_IDLE;
      end
      default: begin
        loadState_next = LD_IDLE;
      end
    endcase
  end

  // control and destination registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_reg         <= '0;
      data_reg         <= '0;
      destAddr_reg     <= '0;
      destPhase_reg    <= 1'b0;
      loadState_reg    <= LD_IDLE;
      choiceSource_reg <= 1'b0;
      freqChoice_reg   <= 1'b0;
      phaseChoice_reg  <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        freqWord_reg[i] <= FREQ_RST;
      end
      for (int i = 0; i < 4; i++) begin
        phaseOffset_reg[i] <= OFS_RST;
      end
    end else begin
      hold_reg         <= hold_next;
      data_reg         <= data_next;
      destAddr_reg     <= destAddr_next;
      destPhase_reg    <= destPhase_next;
      loadState_reg    <= loadState_next;
      choiceSource_reg <= choiceSource_next;
      freqChoice_reg   <= freqChoice_next;
      phaseChoice_reg  <= phaseChoice_next;
      freqWord_reg     <= freqWord_next;
      phaseOffset_reg  <= phaseOffset_next;
    end
  end

  logic             freqSel;
  logic [1:0]       phaseSel;
  logic [ACC_W-1:0] chosenFreqWord;
  logic [OFS_W-1:0] chosenPhaseOffset;
  logic [OFS_W-1:0] lutAddr;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [DAC_W-1:0] dacCode_reg;
  logic [DAC_W-1:0] dacCode_next;

  // selection source: register bits or synchronised pins
  assign freqSel  = choiceSource_reg ? freqChoice_reg : pinSync2_reg[0];
  assign phaseSel = choiceSource_reg ? phaseChoice_reg : pinSync2_reg[2:1];
  assign chosenFreqWord    = freqWord_reg[freqSel];
  assign chosenPhaseOffset = phaseOffset_reg[phaseSel];

  // accumulate and look up; switching words keeps the running phase
  always_comb begin
    acc_next     = acc_reg + chosenFreqWord;
    lutAddr      = acc_reg[ACC_W-1:ACC_W-OFS_W] + chosenPhaseOffset;
    dacCode_next = cosRom[lutAddr];
  end

  // accumulator wraps modulo its width by plain overflow
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_reg     <= FREQ_RST;
      dacCode_reg <= DAC_RST;
    end else begin
      acc_reg     <= acc_next;
      dacCode_reg <= dacCode_next;
    end
  end

  assign dacCode = dacCode_reg;

  // ---------------- checks ----------------
  property p_acc_step;
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> acc_reg == $past(acc_reg) + $past(chosenFreqWord);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

  property p_dac_follows;
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> dacCode_reg ==
      cosRom[$past(acc_reg[ACC_W-1:ACC_W-OFS_W]) + $past(chosenPhaseOffset)];
  endproperty
  a_dac_follows: assert property (p_dac_follows) else $error("dac code mismatch");

  property p_defer_only;
    @(posedge ref_clk) disable iff (sys_rst)
    newWord && (wordCmd == CMD_FREQ_DEFER || wordCmd == CMD_PHASE_DEFER)
    |=> ##1 $stable(freqWord_reg[0]) && $stable(freqWord_reg[1]) &&
        $stable(phaseOffset_reg[0]) && loadState_reg == LD_IDLE;
  endproperty
  a_defer_only: assert property (p_defer_only) else $error("deferred write leaked");

  property p_direct_load;
    @(posedge ref_clk) disable iff (sys_rst)
    newWord && wordCmd == CMD_FREQ_DIRECT && wordAddr == 4'h0
    |=> loadState_reg == LD_WRITE ##1 freqWord_reg[0][WORD_W-1:0] == $past(data_reg);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load late");

  property p_phase_choice;
    @(posedge ref_clk) disable iff (sys_rst)
    newWord && wordCmd == CMD_PHASE_CHOICE && loadState_reg == LD_IDLE
    |=> phaseChoice_reg == {$past(linkWord_reg[PHASE_HIGH_BIT]),
                            $past(linkWord_reg[PHASE_LOW_BIT])};
  endproperty
  a_phase_choice: assert property (p_phase_choice) else $error("phase choice not set");

  property p_freq_choice;
    @(posedge ref_clk) disable iff (sys_rst)
    newWord && (wordCmd == CMD_FREQ_CHOICE || wordCmd == CMD_BOTH_CHOICE) &&
    loadState_reg == LD_IDLE |=> freqChoice_reg == $past(linkWord_reg[FREQ_CHOICE_BIT]);
  endproperty
  a_freq_choice: assert property (p_freq_choice) else $error("freq choice not set");

  // pins reach the selectors exactly two core edges after they are sampled
  property p_pin_source;
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst, 2) && !choiceSource_reg |->
      freqSel == $past(freqWordChoicePin, 2) &&
      phaseSel == {$past(phaseChoiceHighPin, 2), $past(phaseChoiceLowPin, 2)};
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("pin source ignored");

  property p_offset_pick;
    @(posedge ref_clk) disable iff (sys_rst)
    phaseSel == 2'h2 |-> chosenPhaseOffset == phaseOffset_reg[2];
  endproperty
  a_offset_pick: assert property (p_offset_pick) else $error("offset pick wrong");

  // judged as the frame closes: only a full word may raise done
  property p_last_bit;
    @(posedge frameSyncN)
    bitCount_reg != '0 |-> linkDone_reg == (bitCount_reg == FRAME_BITS) &&
      (!linkDone_reg || linkWord_reg == shift_reg);
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("word not published");

endmodule

// ### hdl/dnco_pkg.sv
// constants shared by the numeric oscillator and its serial loader
// assumes one core clock domain plus one serial link clock domain
package dnco_pkg;

  // datapath widths
  localparam int ACC_W   = 32;           // phase accumulator width
  localparam int OFS_W   = 12;           // phase offset and lut address width
  localparam int DAC_W   = 10;           // converter code width
  localparam int WORD_W  = 16;           // serial word width
  localparam int BYTE_W  = 8;
  localparam int CNT_W   = 5;
  localparam int LUT_DEPTH = 4096;
  localparam int QUARTER   = 1024;       // lut entries per quarter wave
  localparam int COS_AMP   = 511;        // peak swing around mid scale
  localparam int DAC_MID   = 512;        // offset binary zero point

  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;   // bits per frame
  localparam logic [CNT_W-1:0] LAST_BIT   = 5'h0f;   // count before the last edge

  // serial word fields
  localparam int CMD_MSB   = 15;
  localparam int CMD_LSB   = 12;
  localparam int ADDR_MSB  = 11;
  localparam int ADDR_LSB  = 8;
  localparam int DATA_MSB  = 7;
  localparam int CTL_MSB   = 15;
  localparam int CTL_LSB   = 14;
  localparam int SOURCE_BIT     = 12;
  localparam int FREQ_CHOICE_BIT = 11;
  localparam int PHASE_HIGH_BIT = 10;
  localparam int PHASE_LOW_BIT  = 9;

  // address fields
  localparam int ADDR_WORD_BIT = 2;      // frequency word 0 or 1
  localparam int ADDR_HALF_BIT = 1;      // 16-bit half of a frequency word
  localparam int ADDR_BYTE_BIT = 0;      // byte of the holding register
  localparam int OFS_IDX_MSB   = 2;      // phase offset index
  localparam int OFS_IDX_LSB   = 1;

  // command codes
  localparam logic [3:0] CMD_PHASE_DIRECT = 4'h0;
  localparam logic [3:0] CMD_PHASE_DEFER  = 4'h1;
  localparam logic [3:0] CMD_FREQ_DIRECT  = 4'h2;
  localparam logic [3:0] CMD_FREQ_DEFER   = 4'h3;
  localparam logic [3:0] CMD_PHASE_CHOICE = 4'h4;
  localparam logic [3:0] CMD_FREQ_CHOICE  = 4'h5;
  localparam logic [3:0] CMD_BOTH_CHOICE  = 4'h6;
  localparam logic [1:0] CTL_SOURCE       = 2'h2;   // top bits of source command

  // reset values
  localparam logic [ACC_W-1:0] FREQ_RST = 32'h0;
  localparam logic [OFS_W-1:0] OFS_RST  = 12'h0;
  localparam logic [DAC_W-1:0] DAC_RST  = 10'h200;

  // destination load sequencer
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b01,
    LD_WRITE = 2'b10
  } dnco_load_t;

endpackage

// ### test/dnco_host_model.sv
// host side of the serial link: framed 16-bit writes, msb first
// assumes the bench calls send() for one frame at a time, never overlapping
`timescale 1ns/1ps

module dnco_host_model (
  output logic serialClk,
  output logic frameSyncN,
  output logic serialDataIn
);
  logic idleHigh;

  initial begin
    idleHigh     = 1'b0;
    serialClk    = 1'b0;
    frameSyncN   = 1'b1;
    serialDataIn = 1'b0;
  end

  // shift the top nBits of word; fewer than 16 aborts the frame
  task automatic send(input logic [15:0] word, input int nBits);
    #37;
    frameSyncN = 1'b0;
    #80;
    for (int i = 15; i > 15 - nBits; i--) begin
      serialClk    = 1'b1;
      serialDataIn = word[i];
      #80;
      serialClk = 1'b0;
      #80;
    end
    frameSyncN   = 1'b1;
    serialDataIn = ~serialDataIn; // released line must not keep its value
    // idle level swaps from frame to frame so both rests are seen; it
    // moves only after the release, so no stray edge lands in the frame
    #80;
    idleHigh  = ~idleHigh;
    serialClk = idleHigh;
    #80;
  endtask
endmodule

// ### test/tb_dnco_serial_loader.sv
// self-checking bench for the numeric oscillator with serial loader
// assumes the cosine table gives 0x3ff at phase 0 and 0x001 at half turn
`timescale 1ns/1ps

module tb_dnco_serial_loader
  import dnco_pkg::*;
;
  localparam logic [DAC_W-1:0] PEAK   = 10'h3ff;
  localparam logic [DAC_W-1:0] TROUGH = 10'h001;

  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             serialClk;
  logic             frameSyncN;
  logic             serialDataIn;
  logic             freqWordChoicePin = 1'b0;
  logic             phaseChoiceLowPin = 1'b0;
  logic             phaseChoiceHighPin = 1'b0;
  logic [DAC_W-1:0] dacCode;
  logic [DAC_W-1:0] v1;
  logic [DAC_W-1:0] v2;
  int               failures = 0;
  int               n_tests = 0;
  int               cycles = 0;

  always #10 ref_clk = ~ref_clk;

  dnco_serial_loader i_dut (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .serialClk          (serialClk),
    .frameSyncN         (frameSyncN),
    .serialDataIn       (serialDataIn),
    .freqWordChoicePin  (freqWordChoicePin),
    .phaseChoiceLowPin  (phaseChoiceLowPin),
    .phaseChoiceHighPin (phaseChoiceHighPin),
    .dacCode            (dacCode)
  );

  dnco_host_model i_host (
    .serialClk    (serialClk),
    .frameSyncN   (frameSyncN),
    .serialDataIn (serialDataIn)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard: whole run is a few thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic expect_true(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s (dac %h)", $time, what, dacCode);
    end
  endtask

  task automatic check(input logic [DAC_W-1:0] expVal, input string what);
    expect_true(dacCode === expVal, what);
  endtask

  // frame, then settle time for the crossing into the core clock
  task automatic write_word(input logic [3:0] cmd, input logic [3:0] addr,
                            input logic [7:0] data);
    // callers pass package command codes or a source command built from CTL_SOURCE, never the reserved one
    i_host.send({cmd, addr, data}, 16);
    wait_clk(8);
  endtask

  // pins pass a two-flop synchroniser before they act
  task automatic set_pins(input logic f, input logic hi, input logic lo);
    @(posedge ref_clk);
    freqWordChoicePin  <= f;
    phaseChoiceHighPin <= hi;
    phaseChoiceLowPin  <= lo;
    wait_clk(6);
  endtask

  // half-turn word steps between peak and trough every cycle
  task automatic check_alt(input string what);
    v1 = dacCode;
    wait_clk(1);
    expect_true(v1 !== dacCode && (dacCode === PEAK || dacCode === TROUGH), what);
  endtask

  task automatic check_hold(input string what);
    v1 = dacCode;
    wait_clk(3);
    expect_true(dacCode === v1, what);
  endtask

  // run on word 0 for n cycles, then freeze on word 1 again
  task automatic run_for(input int n);
    @(posedge ref_clk);
    freqWordChoicePin <= 1'b0;
    repeat (n) @(posedge ref_clk);
    freqWordChoicePin <= 1'b1;
    wait_clk(6);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_clk(4);
    check(PEAK, "reset output");
    write_word(CMD_PHASE_DEFER, 4'h9, 8'h08);
    check(PEAK, "deferred byte reached offset");
    write_word(CMD_PHASE_DIRECT, 4'h8, 8'h00);
    check(TROUGH, "offset 0 half turn");
    // a frame cut short after 15 bits must be dropped
    i_host.send({CMD_PHASE_DIRECT, 4'h8, 8'hff}, 15);
    wait_clk(8);
    check(TROUGH, "aborted frame changed offset");
    // offset 1 at phase 0, offsets 2 and 3 at half turn
    for (int i = 1; i < 4; i++) begin
      write_word(CMD_PHASE_DEFER, 4'h9 + 4'(2 * i), (i == 1) ? 8'h00 : 8'h08);
      write_word(CMD_PHASE_DIRECT, 4'h8 + 4'(2 * i), 8'h00);
    end
    for (int p = 0; p < 4; p++) begin
      set_pins(1'b0, p[1], p[0]);
      check((p == 1) ? PEAK : TROUGH, "pin offset choice");
    end
    // choice bits take over from the pins, which still say 11
    write_word({CTL_SOURCE, 2'b01}, 4'h0, 8'h00);
    write_word(CMD_PHASE_CHOICE, 4'h2, 8'h00);
    check(PEAK, "phase choice bits");
    write_word(CMD_BOTH_CHOICE, 4'h6, 8'h00);
    check(TROUGH, "combined choice bits");
    set_pins(1'b0, 1'b0, 1'b1);
    check(TROUGH, "pins used while bits selected");
    write_word({CTL_SOURCE, 2'b00}, 4'h0, 8'h00);
    check(PEAK, "pins back in control");
    // word 0 lower half 0x0001: drift far too slow to reach the table address
    write_word(CMD_FREQ_DEFER, 4'h1, 8'h00);
    write_word(CMD_FREQ_DIRECT, 4'h0, 8'h01);
    // word 0 upper half 0x8000: half a turn per cycle
    write_word(CMD_FREQ_DEFER, 4'h3, 8'h80);
    write_word(CMD_FREQ_DIRECT, 4'h2, 8'h00);
    check_alt("word 0 half turn step");
    set_pins(1'b1, 1'b0, 1'b1);
    check_hold("word 1 zero holds phase");
    run_for(4);
    v2 = dacCode;
    run_for(5);
    expect_true(v2 !== dacCode, "phase cleared on word switch");
    // frequency choice bit overrides the pin, which says word 1
    write_word({CTL_SOURCE, 2'b01}, 4'h0, 8'h00);
    write_word(CMD_FREQ_CHOICE, 4'h0, 8'h00);
    check_alt("frequency bit picks word 0");
    write_word(CMD_FREQ_CHOICE, 4'h8, 8'h00);
    check_hold("frequency bit picks word 1");
    final_report();
  end
endmodule
